// [cssr_defs.svh]
`ifndef CSSR_DEFS_SVH
`define CSSR_DEFS_SVH

// Status words
`define CSSR_SW_OK 16'h9000
`define CSSR_SW_CONFLICT 16'h6985
`define CSSR_SW_TOKEN_BAD 16'h6982
`define CSSR_SW_MIN_TOO_LONG 16'h9864
`define CSSR_SW_BAD_PARAM 16'h6A00
`define CSSR_SW_NONE 16'h0000

// Parameter byte fields
`define CSSR_P1_OP_BIT 0
`define CSSR_P1_RESERVED_MASK 8'hFE
`define CSSR_P2_ZERO 8'h00
`define CSSR_SUSP_LC 8'h04
`define CSSR_SUSP_LE 8'h0A
`define CSSR_RES_LC 8'h08
`define CSSR_RSP_LEN_NONE 8'h00
`define CSSR_SELECT_P1_BY_NAME 8'h04

// Duration time units
`define CSSR_UNIT_SEC 8'h00
`define CSSR_UNIT_MIN 8'h01
`define CSSR_UNIT_HOUR 8'h02
`define CSSR_UNIT_DAY 8'h03
`define CSSR_UNIT_DAY10 8'h04

// Seconds per unit
`define CSSR_MULT_SEC 28'h0000001
`define CSSR_MULT_MIN 28'h000003C
`define CSSR_MULT_HOUR 28'h0000E10
`define CSSR_MULT_DAY 28'h0015180
`define CSSR_MULT_DAY10 28'h00D2F00

// Instruction codes, arbitrary defaults
`define CSSR_INS_SUSPEND 8'h01
`define CSSR_INS_SELECT 8'h02
`define CSSR_INS_READ_BINARY 8'h03
`define CSSR_INS_READ_RECORD 8'h04
`define CSSR_INS_TERM_CAP 8'h05

`define CSSR_LFSR_SEED 64'h0123456789ABCDEF
`define CSSR_STATE_W 128
`define CSSR_SECS_W 28

`endif

// [cssr_pkg.sv]
`include "cssr_defs.svh"

package cssr_pkg;

    typedef enum logic [1:0] {
        CSSR_IDLE,
        CSSR_DECODE,
        CSSR_NVM_WAIT,
        CSSR_RESPOND
    } cssr_fsm_type;

    typedef logic [`CSSR_SECS_W-1:0] cssr_secs_type;

    function automatic logic cssr_unit_ok(input logic [15:0] dur);
        cssr_unit_ok = (dur[15:8] <= `CSSR_UNIT_DAY10);
    endfunction

    // Unknown units map to zero; callers reject them in term_min and term_max, not in card_max
    function automatic cssr_secs_type cssr_to_secs(input logic [15:0] dur);
        cssr_secs_type mult;
        cssr_secs_type count;
        mult = '0;
        count = {20'h00000, dur[7:0]};
        case (dur[15:8])
            `CSSR_UNIT_SEC: mult = `CSSR_MULT_SEC;
            `CSSR_UNIT_MIN: mult = `CSSR_MULT_MIN;
            `CSSR_UNIT_HOUR: mult = `CSSR_MULT_HOUR;
            `CSSR_UNIT_DAY: mult = `CSSR_MULT_DAY;
            `CSSR_UNIT_DAY10: mult = `CSSR_MULT_DAY10;
            default: mult = '0;
        endcase
        cssr_to_secs = cssr_secs_type'(count * mult);
    endfunction

endpackage

// [cssr_token_lfsr.sv]
`timescale 1ns/100ps
`include "cssr_defs.svh"

module cssr_token_lfsr
    import cssr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic entropy_in,
    output logic [63:0] token
);

    logic [63:0] lfsr_q;
    logic [63:0] lfsr_d;
    wire feedback = lfsr_q[63] ^ lfsr_q[62] ^ lfsr_q[60] ^ lfsr_q[59];

    // Entropy stirred in each cycle so tokens differ across power cycles
    assign lfsr_d = {lfsr_q[62:0], feedback ^ entropy_in};
    assign token = lfsr_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lfsr_q <= `CSSR_LFSR_SEED;
        end else begin
            lfsr_q <= lfsr_d;
        end
    end

endmodule

// [cssr_duration_cmp.sv]
`timescale 1ns/100ps
`include "cssr_defs.svh"

module cssr_duration_cmp
    import cssr_pkg::*;
(
    input wire logic [15:0] term_min,
    input wire logic [15:0] term_max,
    input wire logic [15:0] card_max,
    output logic unit_bad,
    output logic min_too_long,
    output logic [15:0] agreed
);

    wire cssr_secs_type min_s = cssr_to_secs(term_min);
    wire cssr_secs_type max_s = cssr_to_secs(term_max);
    wire cssr_secs_type card_s = cssr_to_secs(card_max);

    assign unit_bad = !cssr_unit_ok(term_min) || !cssr_unit_ok(term_max);
    assign min_too_long = (min_s > card_s);
    // Inverted window from the terminal falls back to its minimum
    assign agreed = (max_s < min_s) ? term_min :
                    (max_s <= card_s) ? term_max : card_max;

endmodule

// [cssr_top.sv]
// Function
// - Lowest bit of first parameter picks suspend or resume; upper bits reserved zero.
// - Accepted suspend saves the whole session state to non-volatile storage.
// - Suspend refused with conflict status on proactive, bearer or secure channel.
// - Card may refuse suspend with the conflict status for internal reasons.
// - Proposed minimum time beyond card limit refuses suspend with 9864.
// - Successful suspend stores a random eight-byte token with the saved state.
// - Reported maximum time lies between the proposed minimum and maximum.
// - Successful suspend never answers with the pending proactive status.
// - Suspend has zero parameter bytes, four data bytes, ten response bytes.
// - Suspend response holds agreed maximum time then the eight token bytes.
// - Durations are a unit byte then a count byte.
// - Any resume command erases the saved state, success or not.
// - Only four command kinds may precede resume; their state is discarded.
// - Any other command erases the saved state and keeps current state.
// - Resume without valid saved state is refused with 6985.
// - Token mismatch returns 6982; match restores state and returns 9000.
// - Resume has first parameter 01, second zero, eight token bytes, no response.
`timescale 1ns/100ps
`include "cssr_defs.svh"

module cssr_top
    import cssr_pkg::*;
#(
    parameter logic [7:0] INS_SUSPEND = `CSSR_INS_SUSPEND,
    parameter logic [7:0] INS_SELECT = `CSSR_INS_SELECT,
    parameter logic [7:0] INS_READ_BINARY = `CSSR_INS_READ_BINARY,
    parameter logic [7:0] INS_READ_RECORD = `CSSR_INS_READ_RECORD,
    parameter logic [7:0] INS_TERM_CAP = `CSSR_INS_TERM_CAP
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_ins,
    input wire logic [7:0] cmd_p1,
    input wire logic [7:0] cmd_p2,
    input wire logic [7:0] cmd_lc,
    input wire logic cmd_le_present,
    input wire logic [7:0] cmd_le,
    input wire logic [63:0] cmd_data,
    input wire logic proactive_active,
    input wire logic bearer_independent_channel_open,
    input wire logic secure_channel_active,
    input wire logic internal_refuse,
    input wire logic [15:0] card_max_duration,
    input wire logic entropy_in,
    input wire logic [`CSSR_STATE_W-1:0] session_state,
    input wire logic nvm_wr_done,
    output logic nvm_wr_req,
    output logic nvm_erase,
    output logic saved_valid,
    output logic restore_valid,
    output logic [`CSSR_STATE_W-1:0] restore_state,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic rsp_handled,
    output logic [15:0] rsp_sw,
    output logic [7:0] rsp_len,
    output logic [79:0] rsp_data
);

    cssr_fsm_type state_q;
    cssr_fsm_type state_d;

    logic cmd_ready_q;
    logic [7:0] ins_q;
    logic [7:0] p1_q;
    logic [7:0] p2_q;
    logic [7:0] lc_q;
    logic le_present_q;
    logic [7:0] le_q;
    logic [63:0] data_q;

    logic [`CSSR_STATE_W-1:0] saved_state_q;
    logic [63:0] saved_token_q;
    logic saved_valid_q;
    logic nvm_wr_req_q;
    logic nvm_erase_q;
    logic restore_valid_q;
    logic [`CSSR_STATE_W-1:0] restore_state_q;

    logic rsp_valid_q;
    logic rsp_handled_q;
    logic [15:0] rsp_sw_q;
    logic [7:0] rsp_len_q;
    logic [79:0] rsp_data_q;

    logic [63:0] fresh_token;
    logic unit_bad;
    logic min_too_long;
    logic [15:0] agreed_max;

    cssr_token_lfsr u_token (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .entropy_in(entropy_in),
        .token(fresh_token)
    );

    cssr_duration_cmp u_duration (
        .term_min(data_q[63:48]),
        .term_max(data_q[47:32]),
        .card_max(card_max_duration),
        .unit_bad(unit_bad),
        .min_too_long(min_too_long),
        .agreed(agreed_max)
    );

    // Phase decode
    wire in_idle = (state_q == CSSR_IDLE);
    wire in_decode = (state_q == CSSR_DECODE);
    wire in_nvm_wait = (state_q == CSSR_NVM_WAIT);
    wire in_respond = (state_q == CSSR_RESPOND);
    wire cmd_take = in_idle && cmd_valid && cmd_ready_q;
    wire rsp_done = in_respond && rsp_valid_q && rsp_ready;

    // Command decode
    wire ins_is_ours = (ins_q == INS_SUSPEND);
    wire op_resume = p1_q[`CSSR_P1_OP_BIT];
    wire p1_reserved_bad = ((p1_q & `CSSR_P1_RESERVED_MASK) != 8'h00);
    wire is_suspend = ins_is_ours && !op_resume;
    wire is_resume = ins_is_ours && op_resume;

    wire susp_format_ok = (p2_q == `CSSR_P2_ZERO)
                          && (lc_q == `CSSR_SUSP_LC)
                          && le_present_q
                          && (le_q == `CSSR_SUSP_LE);
    wire res_format_ok = (p2_q == `CSSR_P2_ZERO)
                         && (lc_q == `CSSR_RES_LC)
                         && !le_present_q;

    wire susp_param_bad = p1_reserved_bad || !susp_format_ok || unit_bad;
    wire res_param_bad = p1_reserved_bad || !res_format_ok;

    // Live sessions and open channels cannot be carried across a power-down
    wire conflict_session = proactive_active;
    wire conflict_bearer = bearer_independent_channel_open;
    wire conflict_secure = secure_channel_active;
    // Free hook: the card may refuse for reasons of its own
    wire conflict_internal = internal_refuse;
    wire susp_conflict = conflict_session || conflict_bearer
                         || conflict_secure || conflict_internal;

    // Malformed commands are checked before conflicts and limits
    wire [15:0] susp_sw = susp_param_bad ? `CSSR_SW_BAD_PARAM :
                          susp_conflict ? `CSSR_SW_CONFLICT :
                          min_too_long ? `CSSR_SW_MIN_TOO_LONG :
                          `CSSR_SW_OK;
    wire susp_go = is_suspend && (susp_sw == `CSSR_SW_OK);

    // Full-width compare, so no partial token ever restores
    wire token_match = (data_q == saved_token_q);
    wire [15:0] res_sw = res_param_bad ? `CSSR_SW_BAD_PARAM :
                         !saved_valid_q ? `CSSR_SW_CONFLICT :
                         token_match ? `CSSR_SW_OK : `CSSR_SW_TOKEN_BAD;
    wire res_restore = is_resume && (res_sw == `CSSR_SW_OK);

    // Commands that may come before a resume without losing it
    wire permitted_cmd = ((ins_q == INS_SELECT) && (p1_q != `CSSR_SELECT_P1_BY_NAME))
                         || (ins_q == INS_READ_BINARY)
                         || (ins_q == INS_READ_RECORD)
                         || (ins_q == INS_TERM_CAP);
    // A suspend lies outside the permitted set too, so even a refused one
    // drops an image that is still waiting to be resumed
    wire foreign_erase = !is_resume && !permitted_cmd;

    wire erase_now = in_decode && saved_valid_q && (is_resume || foreign_erase);
    wire save_load = in_decode && susp_go;
    wire save_commit = in_nvm_wait && nvm_wr_done;
    wire restore_now = in_decode && res_restore;
    // Request stands until storage confirms, so a slow write is never cut
    wire wr_hold = nvm_wr_req_q && !nvm_wr_done;

    // Answer assembly
    wire [15:0] decode_sw = is_suspend ? susp_sw :
                            is_resume ? res_sw : `CSSR_SW_NONE;
    wire [7:0] decode_len = susp_go ? `CSSR_SUSP_LE : `CSSR_RSP_LEN_NONE;
    wire [79:0] decode_data = susp_go ? {agreed_max, fresh_token} : 80'h0;
    // A good suspend answers only after storage confirms the write
    wire rsp_launch = (in_decode && !susp_go) || save_commit;

    // State sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            CSSR_IDLE: begin
                if (cmd_take) begin
                    state_d = CSSR_DECODE;
                end
            end
            CSSR_DECODE: begin
                state_d = susp_go ? CSSR_NVM_WAIT : CSSR_RESPOND;
            end
            // Unbounded: storage that never answers stalls the card
            CSSR_NVM_WAIT: begin
                if (nvm_wr_done) begin
                    state_d = CSSR_RESPOND;
                end
            end
            CSSR_RESPOND: begin
                if (rsp_ready) begin
                    state_d = CSSR_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= CSSR_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Ready drops on take and returns only once the answer is gone
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cmd_ready_q <= 1'b0;
        end else if (cmd_take) begin
            cmd_ready_q <= 1'b0;
        end else if (in_idle || rsp_done) begin
            cmd_ready_q <= 1'b1;
        end
    end

    // Header captured once per take; decode reads only these copies
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ins_q <= 8'h00;
            p1_q <= 8'h00;
            p2_q <= 8'h00;
            lc_q <= 8'h00;
            le_present_q <= 1'b0;
            le_q <= 8'h00;
            data_q <= 64'h0;
        end else if (cmd_take) begin
            ins_q <= cmd_ins;
            p1_q <= cmd_p1;
            p2_q <= cmd_p2;
            lc_q <= cmd_lc;
            le_present_q <= cmd_le_present;
            le_q <= cmd_le;
            data_q <= cmd_data;
        end
    end

    // Saved image; token drawn in the same cycle as the state
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            saved_state_q <= '0;
            saved_token_q <= 64'h0;
        end else if (save_load) begin
            saved_state_q <= session_state;
            saved_token_q <= fresh_token;
        end
    end

    // Valid only once storage confirms, so a lost write is never resumed
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            saved_valid_q <= 1'b0;
        end else if (save_commit) begin
            saved_valid_q <= 1'b1;
        end else if (erase_now || save_load) begin
            saved_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            nvm_wr_req_q <= 1'b0;
            nvm_erase_q <= 1'b0;
        end else begin
            nvm_wr_req_q <= save_load || wr_hold;
            nvm_erase_q <= erase_now;
        end
    end

    // Restore overrides any state left by the permitted commands
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            restore_valid_q <= 1'b0;
            restore_state_q <= '0;
        end else begin
            restore_valid_q <= restore_now;
            if (restore_now) begin
                restore_state_q <= saved_state_q;
            end
        end
    end

    // One answer per take, held until the terminal accepts it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rsp_valid_q <= 1'b0;
        end else if (rsp_launch) begin
            rsp_valid_q <= 1'b1;
        end else if (rsp_done) begin
            rsp_valid_q <= 1'b0;
        end
    end

    // Fields load in decode even for a good suspend and wait behind the write
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rsp_handled_q <= 1'b0;
            rsp_sw_q <= `CSSR_SW_NONE;
            rsp_len_q <= `CSSR_RSP_LEN_NONE;
            rsp_data_q <= 80'h0;
        end else if (in_decode) begin
            rsp_handled_q <= ins_is_ours;
            rsp_sw_q <= decode_sw;
            rsp_len_q <= decode_len;
            rsp_data_q <= decode_data;
        end
    end

    // Command side
    assign cmd_ready = cmd_ready_q;

    // Storage side
    assign nvm_wr_req = nvm_wr_req_q;
    assign nvm_erase = nvm_erase_q;
    assign saved_valid = saved_valid_q;
    assign restore_valid = restore_valid_q;
    assign restore_state = restore_state_q;

    // Response side
    assign rsp_valid = rsp_valid_q;
    assign rsp_handled = rsp_handled_q;
    assign rsp_sw = rsp_sw_q;
    assign rsp_len = rsp_len_q;
    assign rsp_data = rsp_data_q;

endmodule

// [cssr_top_assertions.sv]
`timescale 1ns/100ps
`include "cssr_defs.svh"

module cssr_top_checker (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic nvm_wr_done,
    input wire logic nvm_wr_req,
    input wire logic nvm_erase,
    input wire logic saved_valid,
    input wire logic restore_valid,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [15:0] rsp_sw,
    input wire logic [7:0] rsp_len,
    input wire logic [79:0] rsp_data
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    property p_take_busy; cmd_valid && cmd_ready |=> !cmd_ready; endproperty
    a_take_busy: assert property (p_take_busy)
        else $error("ready stayed high after a take");
    property p_one_answer; cmd_valid && cmd_ready |-> ##2 (rsp_valid != nvm_wr_req); endproperty
    a_one_answer: assert property (p_one_answer)
        else $error("no single answer two cycles after a take");
    property p_rsp_hold;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable({rsp_sw, rsp_len, rsp_data});
    endproperty
    a_rsp_hold: assert property (p_rsp_hold)
        else $error("response changed while stalled");
    property p_rsp_done; rsp_valid && rsp_ready |=> !rsp_valid && cmd_ready; endproperty
    a_rsp_done: assert property (p_rsp_done)
        else $error("response not retired on ready");
    property p_no_pending; rsp_valid |-> rsp_sw[15:8] != 8'h91; endproperty
    a_no_pending: assert property (p_no_pending)
        else $error("pending proactive status returned");
    property p_save_done;
        $rose(saved_valid) |-> $fell(nvm_wr_req) && rsp_valid && rsp_len == 8'h0A;
    endproperty
    a_save_done: assert property (p_save_done)
        else $error("save flagged without finished write and answer");
    property p_wr_stand; nvm_wr_req && !nvm_wr_done |=> nvm_wr_req; endproperty
    a_wr_stand: assert property (p_wr_stand)
        else $error("storage write dropped before done");
    property p_long_ok; rsp_valid && rsp_len == 8'h0A |-> rsp_sw == 16'h9000 && saved_valid; endproperty
    a_long_ok: assert property (p_long_ok)
        else $error("ten byte answer without a good save");
    property p_restore;
        restore_valid |-> rsp_valid && rsp_sw == 16'h9000 && nvm_erase && !saved_valid;
    endproperty
    a_restore: assert property (p_restore)
        else $error("restore without good status and erase");
    property p_erase_pulse; nvm_erase |-> !saved_valid ##1 !nvm_erase; endproperty
    a_erase_pulse: assert property (p_erase_pulse)
        else $error("erase not a pulse or image kept");
    property p_refused; rsp_valid && rsp_sw != 16'h9000 |-> rsp_len == 8'h00 && rsp_data == 80'h0;
    endproperty
    a_refused: assert property (p_refused)
        else $error("refusal carried response data");

    c_save: cover property ($rose(saved_valid));
    c_restore: cover property (restore_valid);
    c_erase: cover property (nvm_erase && !restore_valid);
    c_stall: cover property (rsp_valid && !rsp_ready ##1 rsp_valid);
endmodule

bind cssr_top cssr_top_checker u_checker (
    .clk_sys, .sys_rst, .cmd_valid, .cmd_ready, .nvm_wr_done, .nvm_wr_req, .nvm_erase,
    .saved_valid, .restore_valid, .rsp_valid, .rsp_ready, .rsp_sw, .rsp_len, .rsp_data
);

// [cssr_nvm_model.sv]
`timescale 1ns/100ps

module cssr_nvm_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic nvm_wr_req,
    input wire logic [7:0] wr_delay,
    output logic nvm_wr_done
);
    logic [7:0] wait_q;

    // Storage answers after wr_delay extra cycles, one pulse per write
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !nvm_wr_req) begin
            wait_q <= 8'h00;
            nvm_wr_done <= 1'b0;
        end else begin
            wait_q <= wait_q + 8'h01;
            nvm_wr_done <= (wait_q == wr_delay) && !nvm_wr_done;
        end
    end
endmodule

// [cssr_top_test.sv]
`timescale 1ns/100ps
`include "cssr_defs.svh"

module cssr_top_test;
    typedef struct {
        logic [7:0] ins, p1, lc;
        logic [63:0] data;
        logic [3:0] flags;
        logic [15:0] cmax, sw, agreed;
        logic handled, saved;
    } cssr_row_type;
    localparam logic [63:0] GOOD = 64'h000A_0078_0000_0000;

    logic clk_sys = 1'b0;
    logic sys_rst, cmd_valid, cmd_ready, cmd_le_present, entropy_in, nvm_wr_done, nvm_wr_req;
    logic proactive_active, bearer_independent_channel_open, secure_channel_active;
    logic internal_refuse, nvm_erase, saved_valid, restore_valid, rsp_valid, rsp_ready;
    logic rsp_handled, g_h, g_rv;
    logic [7:0] cmd_ins, cmd_p1, cmd_p2, cmd_lc, cmd_le, rsp_len, wr_delay, g_len;
    logic [15:0] card_max_duration, rsp_sw, g_sw;
    logic [63:0] cmd_data, tok;
    logic [79:0] rsp_data, g_data;
    logic [`CSSR_STATE_W-1:0] session_state, restore_state;
    int n_fail = 0;
    int total_checks = 0;
    cssr_row_type rows [15];
    cssr_row_type r;

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) entropy_in <= ~entropy_in;

    cssr_nvm_model u_nvm (.clk_sys, .sys_rst, .nvm_wr_req, .wr_delay, .nvm_wr_done);

    cssr_top dut (
        .clk_sys, .sys_rst, .cmd_valid, .cmd_ready, .cmd_ins, .cmd_p1, .cmd_p2, .cmd_lc,
        .cmd_le_present, .cmd_le, .cmd_data, .proactive_active, .bearer_independent_channel_open,
        .secure_channel_active, .internal_refuse, .card_max_duration, .entropy_in,
        .session_state, .nvm_wr_done, .nvm_wr_req, .nvm_erase, .saved_valid, .restore_valid,
        .restore_state, .rsp_valid, .rsp_ready, .rsp_handled, .rsp_sw, .rsp_len, .rsp_data
    );

    task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Offers a command, then stalls the answer two cycles before retiring it
    task automatic send(input logic [7:0] ins, p1, lc, input logic [63:0] data);
        int n;
        n = 0;
        {cmd_ins, cmd_p1, cmd_lc, cmd_data} = {ins, p1, lc, data};
        cmd_le_present = (ins == 8'h01) && !p1[0];
        cmd_le = cmd_le_present ? 8'h0A : 8'h00;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1 n++;
        end
        @(posedge clk_sys);
        #1 cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1 n++;
        end
        check("answer raised", 1'b1, rsp_valid);
        {g_sw, g_len, g_data} = {rsp_sw, rsp_len, rsp_data};
        {g_h, g_rv} = {rsp_handled, restore_valid};
        repeat (2) @(posedge clk_sys);
        #1 rsp_ready = 1'b1;
        @(posedge clk_sys);
        #1 rsp_ready = 1'b0;
    endtask

    initial begin
        #20000;
        n_fail++;
        $display("watchdog expired");
        tally_and_finish;
    end

    initial begin
        {cmd_valid, cmd_ins, cmd_p1, cmd_p2, cmd_lc, cmd_le_present, cmd_le, cmd_data} = '0;
        {proactive_active, bearer_independent_channel_open, secure_channel_active} = '0;
        {internal_refuse, card_max_duration, entropy_in, session_state, rsp_ready} = '0;
        sys_rst = 1'b1;
        wr_delay = 8'h00;
        rows = '{
            '{8'h01, 8'h01, 8'h08, 64'h0, 4'h0, 16'h00C8, 16'h6985, 16'h0, 1'b1, 1'b0},
            '{8'h01, 8'h02, 8'h04, GOOD, 4'h0, 16'h00C8, 16'h6A00, 16'h0, 1'b1, 1'b0},
            '{8'h01, 8'h00, 8'h05, GOOD, 4'h0, 16'h00C8, 16'h6A00, 16'h0, 1'b1, 1'b0},
            '{8'h01, 8'h00, 8'h04, 64'h050A_0078_0000_0000, 4'h0, 16'h00C8, 16'h6A00, 16'h0, 1'b1,
                1'b0},
            '{8'h01, 8'h00, 8'h04, GOOD, 4'h8, 16'h00C8, 16'h6985, 16'h0, 1'b1, 1'b0},
            '{8'h01, 8'h00, 8'h04, GOOD, 4'h4, 16'h00C8, 16'h6985, 16'h0, 1'b1, 1'b0},
            '{8'h01, 8'h00, 8'h04, GOOD, 4'h2, 16'h00C8, 16'h6985, 16'h0, 1'b1, 1'b0},
            '{8'h01, 8'h00, 8'h04, GOOD, 4'h1, 16'h00C8, 16'h6985, 16'h0, 1'b1, 1'b0},
            '{8'h01, 8'h00, 8'h04, 64'h0105_0078_0000_0000, 4'h0, 16'h00C8, 16'h9864, 16'h0, 1'b1,
                1'b0},
            '{8'h03, 8'h00, 8'h00, 64'h0, 4'h0, 16'h00C8, 16'h0000, 16'h0, 1'b0, 1'b0},
            '{8'h01, 8'h00, 8'h04, 64'h0101_0078_0000_0000, 4'h0, 16'h003C, 16'h9000, 16'h003C,
                1'b1, 1'b1},
            '{8'h01, 8'h00, 8'h04, 64'h0201_0401_0000_0000, 4'h0, 16'h0302, 16'h9000, 16'h0302,
                1'b1, 1'b1},
            '{8'h02, 8'h00, 8'h00, 64'h0, 4'h0, 16'h0302, 16'h0000, 16'h0, 1'b0, 1'b1},
            '{8'h05, 8'h00, 8'h00, 64'h0, 4'h0, 16'h0302, 16'h0000, 16'h0, 1'b0, 1'b1},
            '{8'h02, 8'h04, 8'h00, 64'h0, 4'h0, 16'h0302, 16'h0000, 16'h0, 1'b0, 1'b0}
        };
        repeat (5) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        check("reset", 128'h0, {cmd_ready, nvm_wr_req, nvm_erase, saved_valid, rsp_valid, rsp_sw});
        @(posedge clk_sys);
        #1 check("ready", 1'b1, cmd_ready);
        $display("reset test done");
        foreach (rows[i]) begin
            r = rows[i];
            {proactive_active, bearer_independent_channel_open, secure_channel_active,
                internal_refuse} = r.flags;
            card_max_duration = r.cmax;
            send(r.ins, r.p1, r.lc, r.data);
            check($sformatf("row %0d answer", i),
                {r.sw, ((r.agreed != 16'h0) ? 8'h0A : 8'h00), r.handled, r.agreed},
                {g_sw, g_len, g_h, g_data[79:64]});
            check($sformatf("row %0d saved", i), r.saved, saved_valid);
            $display("row %0d done", i);
        end
        // Slow storage, then a tampered and a repeated token
        wr_delay = 8'h06;
        session_state = {4{32'h5A5A_0001}};
        send(8'h05, 8'h00, 8'h00, 64'h0);
        send(8'h01, 8'h00, 8'h04, GOOD);
        check("slow save", {16'h9000, 8'h0A, 16'h0078}, {g_sw, g_len, g_data[79:64]});
        tok = g_data[63:0];
        // Session state changed after the good save, with no reset; permitted commands run on
        session_state = {4{32'h5A5A_0002}};
        send(8'h04, 8'h00, 8'h00, 64'h0);
        send(8'h05, 8'h00, 8'h00, 64'h0);
        check("image kept", 1'b1, saved_valid);
        send(8'h01, 8'h01, 8'h08, ~tok);
        check("bad token", {16'h6982, 2'b00}, {g_sw, g_rv, saved_valid});
        send(8'h01, 8'h01, 8'h08, tok);
        check("stale token", 16'h6985, g_sw);
        $display("tampered resume done");
        // Prompt storage; a clean resume brings back the image of the save
        wr_delay = 8'h00;
        send(8'h01, 8'h00, 8'h04, GOOD);
        check("fresh token", 1'b1, g_data[63:0] != tok);
        tok = g_data[63:0];
        session_state = {4{32'h5A5A_0003}};
        send(8'h01, 8'h01, 8'h08, tok);
        check("resume", {16'h9000, 2'b10}, {g_sw, g_rv, saved_valid});
        check("restored", {4{32'h5A5A_0002}}, restore_state);
        $display("clean resume done");
        // Stray second parameter, then a refused suspend over a live image
        cmd_p2 = 8'h01;
        send(8'h01, 8'h00, 8'h04, GOOD);
        check("p2 set", 16'h6A00, g_sw);
        cmd_p2 = 8'h00;
        send(8'h01, 8'h00, 8'h04, GOOD);
        check("image set", 1'b1, saved_valid);
        proactive_active = 1'b1;
        send(8'h01, 8'h00, 8'h04, GOOD);
        check("refused suspend", {16'h6985, 1'b0}, {g_sw, saved_valid});
        proactive_active = 1'b0;
        $display("refused suspend done");
        tally_and_finish;
    end
endmodule
